// *** rtl/ssc_core.v ***
// Status, control and serial data logic of the synchronous serial adapter
//
// What this block does
// - Rising CTS edge latches status bit 3 until clear-CTS or transmitter reset.
// - After clear-CTS, status bit 3 follows live CTS until next rising edge.
// - Underflow in fill mode sets status bit 4; clear command or Tx reset clear.
// - Underflow flag means sync code goes next; output pulses only for sync fill.
// - Overrun sets bit 5; cleared by status then FIFO read, or Rx reset.
// - Bit 6 shows parity error of last FIFO stage; clears on read or Rx reset.
// - DCD activity never clears parity error or receive FIFO flags.
// - Bit 7 reads one exactly while interrupt output is low, same enables.
// - Interrupt drops once all enabled sources clear; no acknowledge needed.
// - Space flag clears at 3 Tx bytes (2 in two-byte mode); data-ready clears at 0 Rx bytes (1 in two-byte).
// - Latched DCD clears on status then FIFO read, or Rx reset.
// - control_one bit 5 enables ready interrupt, bit 4 space; 7..6 select.
// - control_one bit 3 drops receive sync; bit 2 strips sync codes.
// - control_one bits 1 and 0 hold transmitter and receiver in reset.
// - Clear-underflow and clear-CTS command bits clear flags and their interrupt.
// - Command bit 1 picks one or two sync chars; bit 0 external sync.
// - Error enable lets status bits 6 down to 2 request an interrupt.
// - Fill bit one sends sync code on underflow; zero sends all marks.
// - Format bits 5..3 choose data width and parity per the table.
// - Transfer size bit picks one-byte or two-byte meaning of flags.
// - Pin function 00 drives match/ready output high, 10 drives it low.
// - Status register is read-only, eight bits; reading changes no flag.
// - In two-byte mode data-ready needs both last FIFO stages full.
`timescale 1ns/1ps
`include "ssc_map.vh"
module ssc_core
(
  // System clock and reset
  input  wire       clk_sys,
  input  wire       reset,
  // Host register port, synchronous to clk_sys
  input  wire       bus_en,
  input  wire       bus_rw,
  input  wire       register_select_line,
  input  wire [7:0] bus_wdata,
  output reg  [7:0] bus_rdata,
  output reg        irq_n,
  // Serial line pins
  input  wire       ser_clk_pin,
  input  wire       rx_data_pin,
  input  wire       cts_pin,
  input  wire       dcd_pin,
  input  wire       ext_sync_pin,
  output reg        tx_data_pin,
  output reg        underflow_out,
  output reg        match_or_terminal_ready_out
);

  // Data width of a format code
  function [3:0] fmt_bits;
    input [2:0] fmt;
    begin
      case (fmt)
        3'h0, 3'h1: fmt_bits = 4'h6;
        3'h2, 3'h4, 3'h5: fmt_bits = 4'h7;
        default: fmt_bits = 4'h8;
      endcase
    end
  endfunction

  // Mask of the low n bits
  function [7:0] low_mask;
    input [3:0] n;
    begin
      low_mask = 8'hFF >> (4'h8 - n);
    end
  endfunction

  // Parity bit that a character should carry under the format
  function par_bit;
    input [2:0] fmt;
    input [7:0] data;
    begin
      par_bit = (^(data & low_mask(fmt_bits(fmt)))) ^ fmt[0];
    end
  endfunction

  // Pin synchronisers: clk, rx data, CTS, DCD, external sync
  reg  [4:0] pin_s1_reg;
  reg  [4:0] pin_s2_reg;
  reg  [4:0] pin_s3_reg;
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      pin_s1_reg <= 5'h00;
      pin_s2_reg <= 5'h00;
      pin_s3_reg <= 5'h00;
    end
    else
    begin
      pin_s1_reg <= {ext_sync_pin, dcd_pin, cts_pin, rx_data_pin, ser_clk_pin};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end
  wire link_rise = pin_s2_reg[0] & ~pin_s3_reg[0];
  wire link_fall = ~pin_s2_reg[0] & pin_s3_reg[0];
  wire rx_bit    = pin_s2_reg[1];
  wire cts_live  = pin_s2_reg[2];
  wire dcd_live  = pin_s2_reg[3];
  wire cts_rise  = pin_s2_reg[2] & ~pin_s3_reg[2];
  wire dcd_rise  = pin_s2_reg[3] & ~pin_s3_reg[3];

  // Register file
  reg  [7:0] ctl_one_reg;
  reg  [7:0] ctl_fmt_reg;
  reg  [1:0] ctl_mode_reg;
  reg  [7:0] sync_code_reg;
  reg        clr_uf_reg;
  reg        clr_cts_reg;
  wire [1:0] reg_sel  = ctl_one_reg[`SSC_C1_SEL_HI:`SSC_C1_SEL_LO];
  wire       tx_rst   = ctl_one_reg[`SSC_C1_TXRS];
  wire       rx_rst   = ctl_one_reg[`SSC_C1_RXRS];
  wire [2:0] fmt      = ctl_fmt_reg[`SSC_C2_FMT_HI:`SSC_C2_FMT_LO];
  wire [3:0] dbits    = fmt_bits(fmt);
  wire       has_par  = (fmt != 3'h2) && (fmt != 3'h3);
  wire [3:0] wlen     = dbits + {3'h0, has_par};
  wire [3:0] slen     = (wlen > 4'h8) ? 4'h8 : wlen;
  wire       one_byte = ctl_fmt_reg[`SSC_C2_XSIZE];
  wire       ext_mode = ctl_mode_reg[`SSC_C3_EXTSYNC];

  wire wr_strobe = bus_en & ~bus_rw;
  wire rd_strobe = bus_en & bus_rw;
  wire wr_ctl1   = wr_strobe & ~register_select_line;
  wire wr_cmd    = wr_strobe & register_select_line & (reg_sel == `SSC_SEL_CMD);
  wire wr_fmt    = wr_strobe & register_select_line & (reg_sel == `SSC_SEL_FMT);
  wire wr_sync   = wr_strobe & register_select_line & (reg_sel == `SSC_SEL_SYNC);
  wire wr_txd    = wr_strobe & register_select_line & (reg_sel == `SSC_SEL_TXD);
  wire rd_stat   = rd_strobe & ~register_select_line;
  wire rd_rxd    = rd_strobe & register_select_line;

  // Register writes; clear-CTS and clear-underflow command bits live one clock only
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      ctl_one_reg   <= `SSC_C1_RESET;
      ctl_fmt_reg   <= `SSC_C2_RESET;
      ctl_mode_reg  <= `SSC_C3_RESET;
      sync_code_reg <= `SSC_SYNC_RESET;
      clr_uf_reg    <= 1'b0;
      clr_cts_reg   <= 1'b0;
    end
    else
    begin
      if (wr_ctl1)
        ctl_one_reg <= bus_wdata;
      if (wr_fmt)
        ctl_fmt_reg <= bus_wdata;
      if (wr_sync)
        sync_code_reg <= bus_wdata;
      if (wr_cmd)
        ctl_mode_reg <= bus_wdata[`SSC_C3_ONESYNC:`SSC_C3_EXTSYNC];
      clr_uf_reg  <= wr_cmd & bus_wdata[`SSC_C3_CLRUF];
      clr_cts_reg <= wr_cmd & bus_wdata[`SSC_C3_CLRCTS];
    end
  end

  // Transmit FIFO: stage 0 is the one sent next
  reg  [7:0] tx_mem [0:2];
  reg  [1:0] tx_cnt_reg;
  reg  [8:0] tx_sh_reg;
  reg  [3:0] tx_left_reg;
  reg        uf_pend_reg;
  wire       tx_load = link_fall & ~tx_rst & (tx_left_reg == 4'h0);
  wire       tx_pop  = tx_load & (tx_cnt_reg != 2'h0);
  wire       tx_fill = tx_load & (tx_cnt_reg == 2'h0);
  wire       tx_push = wr_txd & (tx_cnt_reg != `SSC_FIFO_DEPTH);
  wire [7:0] tx_head = tx_mem[0] & low_mask(dbits);
  wire [8:0] tx_dword = {1'b0, tx_head}
                      | ({8'h00, has_par & par_bit(fmt, tx_head)} << dbits);
  wire [7:0] tx_sync = sync_code_reg & low_mask(slen);
  // Sync fill carries parity only in the nine-bit format
  wire [8:0] tx_sword = {wlen > 4'h8 && par_bit(fmt, tx_sync), tx_sync};
  wire [8:0] tx_word  = tx_pop ? tx_dword :
                        ctl_fmt_reg[`SSC_C2_FILL] ? tx_sword : 9'h1FF;
  integer    i;

  // Preloading is allowed while the transmitter is held in reset
  always @(posedge clk_sys)
  begin
    if (reset || (wr_ctl1 && bus_wdata[`SSC_C1_TXRS] && !tx_rst))
    begin
      tx_cnt_reg <= 2'h0;
      for (i = 0; i < 3; i = i + 1)
        tx_mem[i] <= 8'h00;
    end
    else
    begin
      if (tx_pop)
      begin
        tx_mem[0] <= tx_mem[1];
        tx_mem[1] <= tx_mem[2];
      end
      if (tx_push)
        tx_mem[tx_pop ? tx_cnt_reg - 2'h1 : tx_cnt_reg] <= bus_wdata;
      tx_cnt_reg <= tx_cnt_reg + {1'b0, tx_push} - {1'b0, tx_pop};
    end
  end

  // Transmit shifter, bits change on the falling link clock edge
  always @(posedge clk_sys)
  begin
    if (reset || tx_rst)
    begin
      tx_data_pin   <= 1'b1;
      tx_sh_reg     <= 9'h1FF;
      tx_left_reg   <= 4'h0;
      uf_pend_reg   <= 1'b0;
      underflow_out <= 1'b0;
    end
    else
    begin
      if (tx_load)
      begin
        tx_data_pin <= tx_word[0];
        tx_sh_reg   <= {1'b1, tx_word[8:1]};
        tx_left_reg <= wlen - 4'h1;
      end
      else if (link_fall && tx_left_reg != 4'h0)
      begin
        tx_data_pin <= tx_sh_reg[0];
        tx_sh_reg   <= {1'b1, tx_sh_reg[8:1]};
        tx_left_reg <= tx_left_reg - 4'h1;
      end
      // Pulse spans one high half of the link clock, sync fill only
      if (tx_fill && ctl_fmt_reg[`SSC_C2_FILL])
        uf_pend_reg <= 1'b1;
      else if (link_rise)
        uf_pend_reg <= 1'b0;
      if (link_rise && uf_pend_reg)
        underflow_out <= 1'b1;
      else if (link_fall)
        underflow_out <= 1'b0;
    end
  end

  // Receiver framing: hunt for sync, then assemble characters
  reg  [7:0] hunt_reg;
  reg        synced_reg;
  reg        first_reg;
  reg  [8:0] rx_sh_reg;
  reg  [3:0] rx_cnt_reg;
  reg        rx_done_reg;
  reg  [8:0] rx_char_reg;
  wire [7:0] hunt_next = {rx_bit, hunt_reg[7:1]};
  wire       hunt_hit  = ((hunt_next >> (4'h8 - slen)) ==
                          (sync_code_reg & low_mask(slen)));
  wire [8:0] rx_word   = rx_sh_reg | ({8'h00, rx_bit} << rx_cnt_reg);
  wire [7:0] rx_data   = rx_word[7:0] & low_mask(dbits);
  wire       rx_pbit   = rx_word[dbits];
  wire       rx_is_sync = ((rx_word[7:0] & low_mask(slen)) ==
                           (sync_code_reg & low_mask(slen)));
  wire       rx_pe     = has_par & (rx_pbit != par_bit(fmt, rx_data));
  wire       rx_end    = link_rise & synced_reg &
                         (rx_cnt_reg == wlen - 4'h1);

  always @(posedge clk_sys)
  begin
    if (reset || rx_rst || ctl_one_reg[`SSC_C1_CLRSYNC])
    begin
      hunt_reg    <= 8'h00;
      synced_reg  <= 1'b0;
      first_reg   <= 1'b0;
      rx_sh_reg   <= 9'h000;
      rx_cnt_reg  <= 4'h0;
      rx_done_reg <= 1'b0;
      rx_char_reg <= 9'h000;
    end
    else
    begin
      rx_done_reg <= 1'b0;
      if (ext_mode)
        synced_reg <= pin_s2_reg[4];
      if (link_rise)
      begin
        hunt_reg <= hunt_next;
        if (!synced_reg && !ext_mode && hunt_hit)
        begin
          // Sync characters that establish framing are never stored
          first_reg  <= 1'b1;
          synced_reg <= ctl_mode_reg[`SSC_C3_ONESYNC] | first_reg;
          rx_cnt_reg <= 4'h0;
          rx_sh_reg  <= 9'h000;
        end
        else if (synced_reg)
        begin
          rx_sh_reg  <= rx_end ? 9'h000 : rx_word;
          rx_cnt_reg <= rx_end ? 4'h0 : rx_cnt_reg + 4'h1;
        end
      end
      if (rx_end && !(ctl_one_reg[`SSC_C1_STRIP] && rx_is_sync))
      begin
        rx_done_reg <= 1'b1;
        rx_char_reg <= {rx_pe, rx_data};
      end
    end
  end

  // Buffer between assembler and FIFO; full buffer means overrun
  wire       buf_in_ready;
  wire       buf_valid;
  wire [8:0] buf_data;
  reg  [8:0] rx_mem [0:2];
  reg  [1:0] rx_fcnt_reg;
  wire       rx_pop  = rd_rxd & (rx_fcnt_reg != 2'h0);
  wire       rx_take = buf_valid & (rx_fcnt_reg != `SSC_FIFO_DEPTH);
  wire       ovr_set = rx_done_reg & ~buf_in_ready;

  ssc_pair_buf u_pair_buf
  (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .in_valid  (rx_done_reg),
    .in_ready  (buf_in_ready),
    .in_data   (rx_char_reg),
    .out_valid (buf_valid),
    .out_ready (rx_take | rx_rst),
    .out_data  (buf_data)
  );

  // Receive FIFO: stage 0 is the last stage, read first
  always @(posedge clk_sys)
  begin
    if (reset || rx_rst)
    begin
      rx_fcnt_reg <= 2'h0;
      for (i = 0; i < 3; i = i + 1)
        rx_mem[i] <= 9'h000;
    end
    else
    begin
      if (rx_pop)
      begin
        rx_mem[0] <= rx_mem[1];
        rx_mem[1] <= rx_mem[2];
      end
      if (rx_take)
        rx_mem[rx_pop ? rx_fcnt_reg - 2'h1 : rx_fcnt_reg] <= buf_data;
      rx_fcnt_reg <= rx_fcnt_reg + {1'b0, rx_take} - {1'b0, rx_pop};
    end
  end

  // Sticky flags; a set in the same cycle as a clear wins
  reg  cts_lat_reg;
  reg  dcd_lat_reg;
  reg  uf_reg;
  reg  ovr_reg;
  reg  armed_reg;
  wire seq_clear = rd_rxd & armed_reg;
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      cts_lat_reg <= 1'b0;
      dcd_lat_reg <= 1'b0;
      uf_reg      <= 1'b0;
      ovr_reg     <= 1'b0;
      armed_reg   <= 1'b0;
    end
    else
    begin
      cts_lat_reg <= cts_rise |
                     (cts_lat_reg & ~clr_cts_reg & ~tx_rst);
      // DCD touches only its own latch
      dcd_lat_reg <= dcd_rise |
                     (dcd_lat_reg & ~seq_clear & ~rx_rst);
      uf_reg      <= (tx_fill & ctl_fmt_reg[`SSC_C2_FILL]) |
                     (uf_reg & ~clr_uf_reg & ~tx_rst);
      ovr_reg     <= ovr_set | (ovr_reg & ~seq_clear & ~rx_rst);
      // Arming is hidden state, so the status read alters no flag
      if (rd_stat)
        armed_reg <= 1'b1;
      else if (rd_rxd)
        armed_reg <= 1'b0;
    end
  end

  // Live status; after a clear the latch bits follow the pin level
  wire rx_data_ready_flag  = one_byte ? (rx_fcnt_reg != 2'h0)
                       : (rx_fcnt_reg >= 2'h2);
  wire tx_fifo_space_flag = ~tx_rst & ~(cts_live & ~ext_mode) &
              (one_byte ? (tx_cnt_reg != 2'h3)
                        : (tx_cnt_reg <= 2'h1));
  wire pe   = (rx_fcnt_reg != 2'h0) & rx_mem[0][8];
  wire err_src = pe | ovr_reg | uf_reg | cts_lat_reg | dcd_lat_reg;
  wire irq_src = (ctl_one_reg[`SSC_C1_RIE] & rx_data_ready_flag) |
                 (ctl_one_reg[`SSC_C1_TIE] & tx_fifo_space_flag) |
                 (ctl_fmt_reg[`SSC_C2_EIE] & err_src);
  wire [7:0] status = {~irq_n, pe, ovr_reg, uf_reg,
                       cts_lat_reg | cts_live,
                       dcd_lat_reg | dcd_live, tx_fifo_space_flag, rx_data_ready_flag};

  // Read data and pin outputs, all registered
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      bus_rdata <= 8'h00;
      irq_n     <= 1'b1;
      match_or_terminal_ready_out <= 1'b1;
    end
    else
    begin
      if (rd_stat)
        bus_rdata <= status;
      else if (rd_rxd)
        bus_rdata <= rx_mem[0][7:0];
      irq_n <= ~irq_src;
      if (ctl_fmt_reg[1:0] == `SSC_PF_AUDIO_OUT)
        match_or_terminal_ready_out <= 1'b1;
      else if (ctl_fmt_reg[1:0] == `SSC_PF_AUDIO_IN)
        match_or_terminal_ready_out <= 1'b0;
      else
        match_or_terminal_ready_out <= synced_reg;
    end
  end

endmodule

// *** rtl/ssc_map.vh ***
// Register map, field positions and reset values of the serial adapter
`ifndef SSC_MAP_VH
`define SSC_MAP_VH

// Status bits
`define SSC_ST_RDA        0
`define SSC_ST_TX_FIFO_SPACE_FLAG       1
`define SSC_ST_DCD        2
`define SSC_ST_CTS        3
`define SSC_ST_UF         4
`define SSC_ST_OVR        5
`define SSC_ST_PE         6
`define SSC_ST_IRQ        7

// control_one bits
`define SSC_C1_RXRS       0
`define SSC_C1_TXRS       1
`define SSC_C1_STRIP      2
`define SSC_C1_CLRSYNC    3
`define SSC_C1_TIE        4
`define SSC_C1_RIE        5
`define SSC_C1_SEL_HI     7
`define SSC_C1_SEL_LO     6

// control_commands bits
`define SSC_C3_EXTSYNC    0
`define SSC_C3_ONESYNC    1
`define SSC_C3_CLRCTS     2
`define SSC_C3_CLRUF      3

// control_format bits
`define SSC_C2_EIE        7
`define SSC_C2_FILL       6
`define SSC_C2_FMT_HI     5
`define SSC_C2_FMT_LO     3
`define SSC_C2_XSIZE      2

// Register select codes used when the select line is high
`define SSC_SEL_CMD       2'h0
`define SSC_SEL_FMT       2'h1
`define SSC_SEL_SYNC      2'h2
`define SSC_SEL_TXD       2'h3

// Pin function settings
`define SSC_PF_AUDIO_OUT  2'h0
`define SSC_PF_AUDIO_IN   2'h2

// Reset values
`define SSC_C1_RESET      8'h03
`define SSC_C2_RESET      8'h18
`define SSC_C3_RESET      2'h0
`define SSC_SYNC_RESET    8'h00

// FIFO depth in stages
`define SSC_FIFO_DEPTH    2'h3

`endif

// *** rtl/ssc_pair_buf.v ***
// Two-entry valid/ready buffer in the received character path
`timescale 1ns/1ps
module ssc_pair_buf
(
  // Clock and reset
  input  wire       clk_sys,
  input  wire       reset,
  // Filling side
  input  wire       in_valid,
  output wire       in_ready,
  input  wire [8:0] in_data,
  // Draining side
  output wire       out_valid,
  input  wire       out_ready,
  output wire [8:0] out_data
);

  reg [8:0] slot0_reg;
  reg [8:0] slot1_reg;
  reg [1:0] count_reg;
  wire      push;
  wire      pop;

  // Ready is honest: only free space lets a word in
  assign in_ready  = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data  = slot0_reg;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Slot 0 is always the oldest word
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      slot0_reg <= 9'h000;
      slot1_reg <= 9'h000;
      count_reg <= 2'h0;
    end
    else
    begin
      if (pop)
      begin
        slot0_reg <= (push && count_reg == 2'h1) ? in_data : slot1_reg;
      end
      else if (push && count_reg == 2'h0)
      begin
        slot0_reg <= in_data;
      end
      if (push && (count_reg == 2'h2 || (count_reg == 2'h1 && !pop)))
      begin
        slot1_reg <= in_data;
      end
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

// *** sim/ssc_core_checker.sv ***
// Concurrent checks on the serial adapter register block ports
`timescale 1ns/1ps
module ssc_core_checker
(
  // Clock and reset
  input wire       clk_sys,
  input wire       reset,
  // Host side
  input wire       bus_en,
  input wire       bus_rw,
  input wire       register_select_line,
  input wire [7:0] bus_wdata,
  input wire [7:0] bus_rdata,
  input wire       irq_n,
  // Line side
  input wire       ser_clk_pin,
  input wire       rx_data_pin,
  input wire       cts_pin,
  input wire       dcd_pin,
  input wire       ext_sync_pin,
  input wire       tx_data_pin,
  input wire       underflow_out,
  input wire       match_or_terminal_ready_out
);
  reg [7:0] c1_reg;
  reg [7:0] c2_reg;
  wire      fmt_wr;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // Shadow copies of the two control registers, seen from host writes
  assign fmt_wr = bus_en && !bus_rw && register_select_line
                  && c1_reg[7:6] == 2'h1;
  always @(posedge clk_sys)
    if (reset)
    begin
      c1_reg <= 8'h03;
      c2_reg <= 8'h18;
    end
    else if (bus_en && !bus_rw && !register_select_line)
      c1_reg <= bus_wdata;
    else if (fmt_wr)
      c2_reg <= bus_wdata;

  chk_rdata_holds: assert property (
    !(bus_en && bus_rw) |=> $stable(bus_rdata))
    else $error("read data moved without a read");
  chk_irq_bit_mirror: assert property (
    bus_en && bus_rw && !register_select_line
    |=> bus_rdata[7] == !$past(irq_n))
    else $error("status bit 7 disagrees with irq_n");
  chk_pin_audio_out: assert property (
    fmt_wr && bus_wdata[1:0] == 2'h0 |-> ##[1:2] match_or_terminal_ready_out)
    else $error("pin function 00 did not drive high");
  chk_pin_audio_in: assert property (
    fmt_wr && bus_wdata[1:0] == 2'h2 |-> ##[1:2] !match_or_terminal_ready_out)
    else $error("pin function 10 did not drive low");
  chk_fill_gates_pulse: assert property (
    underflow_out |-> c2_reg[6])
    else $error("underflow pulse without fill mode");
  chk_tx_reset_idle: assert property (
    c1_reg[1] [*4] |-> tx_data_pin && !underflow_out)
    else $error("transmitter active while held in reset");
  chk_irq_needs_enable: assert property (
    (!c1_reg[4] && !c1_reg[5] && !c2_reg[7]) [*3] |-> irq_n)
    else $error("interrupt with every enable off");
  chk_cts_raises_irq: assert property (
    c2_reg[7] && !c1_reg[1] && $rose(cts_pin) |-> ##[1:8] !irq_n)
    else $error("clear-to-send edge raised no interrupt");
  chk_dcd_raises_irq: assert property (
    c2_reg[7] && !c1_reg[0] && $rose(dcd_pin) |-> ##[1:8] !irq_n)
    else $error("carrier edge raised no interrupt");
endmodule

// *** sim/ssc_line_model.sv ***
// Behavioural far end of the serial line: link clock and receive data
`timescale 1ns/1ps
module ssc_line_model
(
  // Line pins driven towards the adapter
  output logic ser_clk_pin,
  output logic rx_data_pin,
  output logic ext_sync_pin
);
  initial
  begin
    ser_clk_pin = 1'b0;
    rx_data_pin = 1'b1;
    ext_sync_pin = 1'b0;
  end

  // One 400 ns link period per bit, data set up ahead of the rising edge
  task automatic bit_out(input logic b);
    rx_data_pin = b;
    #200 ser_clk_pin = 1'b1;
    #200 ser_clk_pin = 1'b0;
  endtask

  // Frame of counted bytes, LSB first, external sync held high throughout
  task automatic frame(input logic [7:0] first, input int count);
    logic [7:0] b;
    ext_sync_pin = 1'b1;
    for (int k = 0; k < count; k++)
    begin
      b = first + k[7:0];
      for (int i = 0; i < 8; i++)
        bit_out(b[i]);
    end
    ext_sync_pin = 1'b0;
    rx_data_pin = ~rx_data_pin; // Released line must not keep last bit
  endtask

  // Free clocks with no framing; data toggles so nothing stale is seen
  task automatic idle_clocks(input int n);
    for (int i = 0; i < n; i++)
      bit_out(~rx_data_pin);
  endtask
endmodule

// *** sim/tb_top.sv ***
// Self-checking testbench for the serial adapter register block
`timescale 1ns/1ps
module tb_top;
  logic       clk_sys = 1'b0;
  logic       reset = 1'b1;
  logic       bus_en = 1'b0;
  logic       bus_rw = 1'b0;
  logic       register_select_line = 1'b0;
  logic [7:0] bus_wdata = 8'h00;
  logic       cts_pin = 1'b0;
  logic       dcd_pin = 1'b0;
  logic [7:0] bus_rdata;
  logic       irq_n;
  logic       ser_clk_pin;
  logic       rx_data_pin;
  logic       ext_sync_pin;
  logic       tx_data_pin;
  logic       underflow_out;
  logic       match_or_terminal_ready_out;
  logic       uf_seen = 1'b0;
  logic [7:0] st;
  int         miscompares = 0;
  int         checks = 0;
  int         cycles = 0;

  always #25 clk_sys = ~clk_sys;

  ssc_core dut (.clk_sys, .reset, .bus_en, .bus_rw, .register_select_line,
    .bus_wdata, .bus_rdata, .irq_n, .ser_clk_pin, .rx_data_pin, .cts_pin,
    .dcd_pin, .ext_sync_pin, .tx_data_pin, .underflow_out,
    .match_or_terminal_ready_out);
  ssc_line_model line (.ser_clk_pin, .rx_data_pin, .ext_sync_pin);

  // Pulse is short, so catch it here rather than by polling
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (underflow_out === 1'b1)
      uf_seen <= 1'b1;
    if (cycles == 20000)
    begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    if (miscompares == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  // One-cycle access strobe; inputs change on the falling edge
  task automatic access(input logic rw, input logic rs, input logic [7:0] d);
    @(negedge clk_sys);
    bus_en = 1'b1;
    bus_rw = rw;
    register_select_line = rs;
    bus_wdata = d;
    @(negedge clk_sys);
    bus_en = 1'b0;
  endtask

  task automatic wr(input logic rs, input logic [7:0] d);
    access(1'b0, rs, d);
  endtask

  task automatic rd(input logic rs, output logic [7:0] d);
    access(1'b1, rs, 8'h00);
    d = bus_rdata;
  endtask

  task automatic chk_st(input string n, input logic [7:0] m, input logic [7:0] e);
    rd(1'b0, st);
    cmp(n, e, st & m);
  endtask

  task automatic t_reset;
    chk_st("status after reset", 8'hFF, 8'h00);
    cmp("irq_n idle", 8'h01, {7'h00, irq_n});
    cmp("tx line idle", 8'h01, {7'h00, tx_data_pin});
  endtask

  task automatic t_cts;
    wr(1'b0, 8'h41);
    wr(1'b1, 8'h98); // Error interrupts on, 8 bits no parity
    wr(1'b0, 8'h01);
    cts_pin = 1'b1;
    repeat (10) @(negedge clk_sys);
    chk_st("cts latched", 8'h88, 8'h88);
    cts_pin = 1'b0;
    repeat (10) @(negedge clk_sys);
    chk_st("cts held", 8'h88, 8'h88);
    wr(1'b1, 8'h04);
    repeat (4) @(negedge clk_sys);
    chk_st("cts cleared", 8'h88, 8'h00);
    cmp("irq_n after clear", 8'h01, {7'h00, irq_n});
    cts_pin = 1'b1;
    repeat (10) @(negedge clk_sys);
    chk_st("cts live", 8'h08, 8'h08);
    cts_pin = 1'b0;
    wr(1'b1, 8'h04);
  endtask

  task automatic t_dcd;
    wr(1'b0, 8'h00);
    dcd_pin = 1'b1;
    repeat (10) @(negedge clk_sys);
    dcd_pin = 1'b0;
    repeat (10) @(negedge clk_sys);
    chk_st("dcd latched", 8'hC4, 8'h84);
    rd(1'b1, st);
    repeat (4) @(negedge clk_sys);
    chk_st("dcd cleared", 8'h84, 8'h00);
  endtask

  task automatic t_pin;
    wr(1'b0, 8'h40);
    wr(1'b1, 8'h9A);
    repeat (3) @(negedge clk_sys);
    cmp("audio in", 8'h00, {7'h00, match_or_terminal_ready_out});
    wr(1'b1, 8'h98);
    repeat (3) @(negedge clk_sys);
    cmp("audio out", 8'h01, {7'h00, match_or_terminal_ready_out});
  endtask

  // Five words fit in FIFO plus buffer, the sixth overruns
  task automatic t_overrun;
    wr(1'b0, 8'h00);
    wr(1'b1, 8'h01);
    line.frame(8'h5A, 6);
    repeat (10) @(negedge clk_sys);
    chk_st("overrun ready", 8'hE1, 8'hA1);
    cmp("irq_n overrun", 8'h00, {7'h00, irq_n});
    rd(1'b1, st);
    cmp("rx byte 0", 8'h5A, st);
    repeat (4) @(negedge clk_sys);
    chk_st("overrun cleared", 8'h20, 8'h00);
    for (int k = 1; k < 5; k++)
    begin
      rd(1'b1, st);
      cmp("rx byte", 8'h5A + k[7:0], st);
    end
    repeat (4) @(negedge clk_sys);
    chk_st("drained", 8'h81, 8'h00);
  endtask

  task automatic t_underflow;
    wr(1'b0, 8'h80);
    wr(1'b1, 8'h7E);
    wr(1'b0, 8'h40);
    wr(1'b1, 8'hD8);
    wr(1'b0, 8'h00);
    line.idle_clocks(20);
    repeat (10) @(negedge clk_sys);
    cmp("underflow pulse", 8'h01, {7'h00, uf_seen});
    chk_st("underflow flag", 8'h90, 8'h90);
    wr(1'b1, 8'h09);
    repeat (4) @(negedge clk_sys);
    chk_st("underflow cleared", 8'h90, 8'h00);
  endtask

  // 7 bits even parity, one-byte flags; 80 has bad parity, 81 good
  task automatic t_parity;
    wr(1'b0, 8'h40);
    wr(1'b1, 8'hA4);
    line.frame(8'h80, 2);
    repeat (10) @(negedge clk_sys);
    chk_st("parity flagged", 8'h41, 8'h41);
    rd(1'b1, st);
    cmp("rx 7-bit data", 8'h00, st);
    chk_st("one-byte ready", 8'h41, 8'h01);
    rd(1'b1, st);
    cmp("rx 7-bit good", 8'h01, st);
    chk_st("one-byte empty", 8'h41, 8'h00);
  endtask

  initial
  begin
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    reset = 1'b0;
    t_reset();
    t_cts();
    t_dcd();
    t_pin();
    t_overrun();
    t_underflow();
    t_parity();
    print_verdict();
  end
endmodule

bind ssc_core ssc_core_checker chk (.clk_sys(clk_sys), .reset(reset),
  .bus_en(bus_en), .bus_rw(bus_rw),
  .register_select_line(register_select_line), .bus_wdata(bus_wdata),
  .bus_rdata(bus_rdata), .irq_n(irq_n), .ser_clk_pin(ser_clk_pin),
  .rx_data_pin(rx_data_pin), .cts_pin(cts_pin), .dcd_pin(dcd_pin),
  .ext_sync_pin(ext_sync_pin), .tx_data_pin(tx_data_pin),
  .underflow_out(underflow_out),
  .match_or_terminal_ready_out(match_or_terminal_ready_out));
